// *** cnsb_device.sv ***
// device end: can mode, bus driver control, bus wake detect and stop wake-up pulses
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module cnsb_device (
	input  wire logic     clock,
	input  wire logic     nrst,
	cnsb_if.dev           lnk,
	input  wire logic [2:0] chipMode,     // system chip mode, cnsb_pkg::cnsb_chip_t coding
	input  wire logic     railOn,         // peripheral supply rail present
	input  wire logic     busDomIn,       // bus differential above threshold
	input  wire logic     ocIn,           // regulator overcurrent comparator
	input  wire logic     senseIn,        // wake sense input level
	input  wire logic [8:0] senseMs,      // cyclic sense period in ms
	output logic          busDrive_r,     // bus driver forced dominant
	output logic          driverOn_r,     // bus driver enabled
	output logic          wakeRxOn_r,     // wake receiver enabled
	output logic [1:0]    slewOut_r,      // slew rate to driver
	output logic          senseSwitch_r,  // high side sense switch on
	output logic          stopExit_r      // one-cycle request to leave stop
);
	logic txS, busS, ocS, senseS, csS, csD_r;
	localparam int TW_W = cnsb_pkg::TW;   // short timer width
	logic canNorm, inStop, railTx;
	logic [TW_W-1:0] domCnt_r;
	logic stuck_r;
	logic busDomD_r;
	logic [TW_W-1:0] pulseCnt_r, gapCnt_r;
	logic [13:0] frameCnt_r;
	logic [1:0] pulseNum_r;
	logic wakeDet, busWake_r, sawNormal_r;
	logic [TW_W-1:0] ocCnt_r;
	logic ocDone_r;
	logic [cnsb_pkg::PW-1:0] perCnt_r;
	logic senseHit_r;
	cnsb_pkg::cnsb_wake_t wkSt_r;
	logic [TW_W-1:0] wkCnt_r, wkDelay_r;
	logic intN_r, rxd_r, stuckOut_r, busWakeOut_r;

	// a counter that saturates at its width
	function automatic logic [TW_W-1:0] satInc(input logic [TW_W-1:0] v);
		satInc = (&v) ? v : v + 13'h0001;
	endfunction : satInc

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	cnsb_sync #(.INIT(1'b1)) uTx  (.clock(clock), .nrst(nrst), .din(lnk.txd),  .dout(txS));
	cnsb_sync #(.INIT(1'b0)) uBus (.clock(clock), .nrst(nrst), .din(busDomIn), .dout(busS));
	cnsb_sync #(.INIT(1'b0)) uOc  (.clock(clock), .nrst(nrst), .din(ocIn),     .dout(ocS));
	cnsb_sync #(.INIT(1'b0)) uSen (.clock(clock), .nrst(nrst), .din(senseIn),  .dout(senseS));
	cnsb_sync #(.INIT(1'b1)) uCs  (.clock(clock), .nrst(nrst), .din(lnk.csN),  .dout(csS));

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// chip sleep and stop force can sleep; spi picks otherwise
	assign canNorm = lnk.canNormal
		&& chipMode != cnsb_pkg::CHIP_SLEEP && chipMode != cnsb_pkg::CHIP_STOP;
	assign inStop = (chipMode == cnsb_pkg::CHIP_STOP);
	// pins read low in reset, normal request, sleep, stop and without rail
	assign railTx = railOn && chipMode != cnsb_pkg::CHIP_RESET && chipMode != cnsb_pkg::CHIP_NREQ
		&& chipMode != cnsb_pkg::CHIP_SLEEP && chipMode != cnsb_pkg::CHIP_STOP;

	// ----------------------------------------
	// bus driver and receive pin
	// ----------------------------------------
	// driver off in sleep; leaving sleep drives dominant at once if tx is already low
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			driverOn_r <= 1'b1;
			busDrive_r <= 1'b0;
			slewOut_r  <= 2'h0;
			rxd_r      <= 1'b0;
			wakeRxOn_r <= 1'b0;
		end else begin
			driverOn_r <= canNorm && railTx && domCnt_r < TW_W'(cnsb_pkg::DOM_TOUT_CYC);
			busDrive_r <= canNorm && railTx && !txS && !domCnt_r[TW_W-1] && (domCnt_r < TW_W'(cnsb_pkg::DOM_TOUT_CYC));
			slewOut_r  <= lnk.slew;
			rxd_r      <= railTx && (canNorm ? !busS : 1'b1);
			wakeRxOn_r <= !canNorm && lnk.wakeEn;
		end
	end

	// ----------------------------------------
	// dominant timeout and stuck flag
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) domCnt_r <= '0;
		else if (txS || !canNorm) domCnt_r <= '0;
		else domCnt_r <= satInc(domCnt_r);
	end

	// set wins over the read clear; clear needs condition gone
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) stuck_r <= 1'b0;
		else if (domCnt_r >= TW_W'(cnsb_pkg::DOM_TOUT_CYC)) stuck_r <= 1'b1;
		else if (lnk.statRd && txS) stuck_r <= 1'b0;
	end

	// ----------------------------------------
	// bus pattern wake detector
	// ----------------------------------------
	assign wakeDet = wakeRxOn_r && busDomD_r && !busS
		&& pulseCnt_r >= TW_W'(cnsb_pkg::PULSE_MIN_CYC)
		&& pulseCnt_r < TW_W'(cnsb_pkg::PULSE_MAX_CYC)
		&& pulseNum_r == 2'(cnsb_pkg::WAKE_PULSES - 1)
		&& frameCnt_r < 14'(cnsb_pkg::FRAME_CYC);

	// width, gap and frame timers on the wake receiver
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busDomD_r  <= 1'b0;
			pulseCnt_r <= '0;
			gapCnt_r   <= '0;
			frameCnt_r <= '0;
			pulseNum_r <= 2'h0;
		end else begin
			busDomD_r <= busS;
			if (!wakeRxOn_r) begin
				pulseNum_r <= 2'h0;
				frameCnt_r <= '0;
			end else begin
				if (busS) pulseCnt_r <= satInc(pulseCnt_r);
				else pulseCnt_r <= '0;
				if (!busS) gapCnt_r <= satInc(gapCnt_r);
				else gapCnt_r <= '0;
				if (pulseNum_r != 2'h0 && frameCnt_r < 14'h3fff) frameCnt_r <= frameCnt_r + 14'h0001;
				// a falling edge ends a pulse: count it if valid, else restart
				if (busDomD_r && !busS) begin
					if (pulseCnt_r >= TW_W'(cnsb_pkg::PULSE_MIN_CYC)
						&& pulseCnt_r < TW_W'(cnsb_pkg::PULSE_MAX_CYC)
						&& (pulseNum_r == 2'h0 || frameCnt_r < 14'(cnsb_pkg::FRAME_CYC))) begin
						if (pulseNum_r == 2'(cnsb_pkg::WAKE_PULSES - 1)) pulseNum_r <= 2'h0;
						else pulseNum_r <= pulseNum_r + 2'h1;
						if (pulseNum_r == 2'h0) frameCnt_r <= '0;
					end else begin
						pulseNum_r <= 2'h0;
					end
				end else if (!busS && gapCnt_r >= TW_W'(cnsb_pkg::PULSE_MAX_CYC)) begin
					pulseNum_r <= 2'h0;
				end
			end
		end
	end

	// bus wake flag: cleared only after normal by spi and a read
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			busWake_r   <= 1'b0;
			sawNormal_r <= 1'b0;
		end else if (wakeDet) begin
			busWake_r   <= 1'b1;
			sawNormal_r <= 1'b0;
		end else begin
			if (busWake_r && canNorm) sawNormal_r <= 1'b1;
			if (sawNormal_r && lnk.statRd) begin
				busWake_r   <= 1'b0;
				sawNormal_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// overcurrent deglitch and cyclic sense
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ocCnt_r  <= '0;
			ocDone_r <= 1'b0;
		end else begin
			ocCnt_r  <= ocS ? satInc(ocCnt_r) : '0;
			ocDone_r <= ocS && ocCnt_r == TW_W'(cnsb_pkg::OC_DGLT_CYC - 1);
		end
	end

	// switch on for the on-time at the start of each period, sample before its end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			perCnt_r      <= '0;
			senseSwitch_r <= 1'b0;
			senseHit_r    <= 1'b0;
		end else begin
			if (!inStop || perCnt_r >= cnsb_pkg::PW'(senseMs) * cnsb_pkg::PW'(cnsb_pkg::CYC_PER_MS) - 1'b1)
				perCnt_r <= '0;
			else
				perCnt_r <= perCnt_r + 1'b1;
			senseSwitch_r <= inStop && perCnt_r < cnsb_pkg::PW'(cnsb_pkg::SENSE_ON_CYC);
			senseHit_r <= inStop && senseS
				&& perCnt_r == cnsb_pkg::PW'(cnsb_pkg::SENSE_ON_CYC - cnsb_pkg::SAMPLE_LEAD_CYC);
		end
	end

	// ----------------------------------------
	// stop wake sequencer
	// ----------------------------------------
	// the first event in stop picks the delay; later ones merge into the same pulse
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			csD_r     <= 1'b1;
			wkSt_r    <= cnsb_pkg::WK_IDLE;
			wkCnt_r   <= '0;
			wkDelay_r <= '0;
			intN_r    <= 1'b1;
			stopExit_r <= 1'b0;
		end else begin
			csD_r      <= csS;
			stopExit_r <= 1'b0;
			case (wkSt_r)
			cnsb_pkg::WK_IDLE: begin
				wkCnt_r <= '0;
				if (inStop && csS && !csD_r) begin
					wkDelay_r <= TW_W'(cnsb_pkg::CS_WAKE_CYC);
					wkSt_r    <= cnsb_pkg::WK_WAIT;
				end else if (inStop && ocDone_r) begin
					wkDelay_r <= TW_W'(cnsb_pkg::OC_WAKE_CYC);
					wkSt_r    <= cnsb_pkg::WK_WAIT;
				end else if (inStop && (senseHit_r || wakeDet)) begin
					wkDelay_r <= TW_W'(cnsb_pkg::SENSE_WAKE_CYC);
					wkSt_r    <= cnsb_pkg::WK_WAIT;
				end
			end
			cnsb_pkg::WK_WAIT: begin
				wkCnt_r <= wkCnt_r + 13'h0001;
				if (wkCnt_r >= wkDelay_r - 13'h0002) begin
					wkCnt_r    <= '0;
					intN_r     <= 1'b0;
					stopExit_r <= 1'b1;
					wkSt_r     <= cnsb_pkg::WK_PULS;
				end
			end
			cnsb_pkg::WK_PULS: begin
				wkCnt_r <= wkCnt_r + 13'h0001;
				if (wkCnt_r == TW_W'(cnsb_pkg::INT_PULSE_CYC - 1)) begin
					intN_r <= 1'b1;
					wkSt_r <= cnsb_pkg::WK_IDLE;
				end
			end
			default: wkSt_r <= cnsb_pkg::WK_IDLE;
			endcase
		end
	end

	// registered status to the link
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stuckOut_r   <= 1'b0;
			busWakeOut_r <= 1'b0;
		end else begin
			stuckOut_r   <= stuck_r;
			busWakeOut_r <= busWake_r;
		end
	end

	assign lnk.rxd       = rxd_r;
	assign lnk.intN      = intN_r;
	assign lnk.stuckFlag = stuckOut_r;
	assign lnk.busWake   = busWakeOut_r;
endmodule : cnsb_device

// *** cnsb_pkg.sv ***
// shared constants and types for the can mode and stop wake-up block
package cnsb_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_KHZ          = 10000;             // 10 MHz system clock
	localparam int CS_WAKE_US       = 60;                // chip select edge to wake pulse
	localparam int OC_DGLT_US       = 55;                // regulator overcurrent deglitch
	localparam int OC_WAKE_US       = 60;                // filtered overcurrent to wake pulse
	localparam int SENSE_WAKE_US    = 100;               // sensed wake input to wake pulse
	localparam int SAMPLE_LEAD_US   = 10;                // sample point before end of on-time
	localparam int SENSE_ON_US      = 100;               // sense switch on-time
	localparam int DOM_TOUT_US      = 200;               // least dominant timeout
	localparam int PULSE_MIN_NS     = 500;               // bus wake pulse least width
	localparam int PULSE_MAX_US     = 500;               // bus wake pulse longest width / gap
	localparam int FRAME_US         = 1000;              // three pulses within this window
	localparam int INT_PULSE_US     = 10;                // wake pulse width on host interrupt
	localparam int WAKE_PULSES      = 3;
	localparam int PERIOD_MIN_MS    = 5;                 // shortest cyclic sense period
	localparam int CYC_PER_US       = CLK_KHZ / 1000;
	localparam int CS_WAKE_CYC      = CS_WAKE_US * CYC_PER_US;
	localparam int OC_DGLT_CYC      = OC_DGLT_US * CYC_PER_US;
	localparam int OC_WAKE_CYC      = OC_WAKE_US * CYC_PER_US;
	localparam int SENSE_WAKE_CYC   = SENSE_WAKE_US * CYC_PER_US;
	localparam int SAMPLE_LEAD_CYC  = SAMPLE_LEAD_US * CYC_PER_US;
	localparam int SENSE_ON_CYC     = SENSE_ON_US * CYC_PER_US;
	localparam int DOM_TOUT_CYC     = DOM_TOUT_US * CYC_PER_US;
	localparam int PULSE_MIN_CYC    = (PULSE_MIN_NS * CLK_KHZ + 999999) / 1000000;
	localparam int PULSE_MAX_CYC    = PULSE_MAX_US * CYC_PER_US;
	localparam int FRAME_CYC        = FRAME_US * CYC_PER_US;
	localparam int INT_PULSE_CYC    = INT_PULSE_US * CYC_PER_US;
	localparam int CYC_PER_MS       = CLK_KHZ;
	localparam int TW               = 13;                // short timer width
	localparam int PW               = 22;                // sense period counter width

	// ----------------------------------------
	// register map (own choice), 32-bit aligned
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;           // host controller command
	localparam logic [7:0] REG_STAT   = 8'h04;           // mirrored device status
	localparam logic [7:0] REG_PERIOD = 8'h08;           // cyclic sense period in ms
	localparam int CTRL_NORMAL  = 0;
	localparam int CTRL_WAKEEN  = 1;
	localparam int CTRL_SLEW    = 2;                     // two bits
	localparam int CTRL_TXD     = 4;
	localparam int CTRL_CHIP    = 8;                     // three bits
	localparam int STAT_RXD     = 0;
	localparam int STAT_STUCK   = 2;                     // stuck dominant flag, bit D2
	localparam int STAT_BUSWAKE = 3;
	localparam int STAT_WAKE    = 4;
	localparam logic [8:0] PERIOD_RST = 9'h005;

	typedef enum logic [2:0] {
		CHIP_NREQ    = 3'h0,
		CHIP_NORMAL  = 3'h1,
		CHIP_STANDBY = 3'h3,
		CHIP_STOP    = 3'h2,
		CHIP_SLEEP   = 3'h6,
		CHIP_RESET   = 3'h7
	} cnsb_chip_t;

	typedef enum logic [1:0] {
		WK_IDLE = 2'h0,
		WK_WAIT = 2'h1,
		WK_PULS = 2'h3
	} cnsb_wake_t;
endpackage : cnsb_pkg

// *** cnsb_if.sv ***
// link between the can mode device end and the host controller end
`timescale 1ns/1ns
interface cnsb_if;
	logic       txd;        // transmit pin, high = recessive
	logic       rxd;        // receive pin, low = dominant
	logic       csN;        // spi chip select, active low
	logic       canNormal;  // command: 1 normal, 0 sleep
	logic       wakeEn;     // command: bus wake detect in sleep
	logic [1:0] slew;       // command: slew rate setting
	logic       statRd;     // one-cycle status register read strobe
	logic       stuckFlag;  // latched stuck dominant flag
	logic       busWake;    // latched bus wake flag
	logic       intN;       // host interrupt, active low pulse
	modport dev  (input txd, csN, canNormal, wakeEn, slew, statRd,
		output rxd, stuckFlag, busWake, intN);
	modport host (output txd, csN, canNormal, wakeEn, slew, statRd,
		input rxd, stuckFlag, busWake, intN);
endinterface : cnsb_if

// *** cnsb_sync.sv ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module cnsb_sync #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic din,
	output logic      dout
);
	logic s1, s2, s3;

	// ----------------------------------------
	// sampling chain
	// ----------------------------------------
	// only s2 reads s1
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// output changes once two stages agree
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) dout <= INIT;
		else if (s2 == s3) dout <= s3;
	end
endmodule : cnsb_sync

// *** cnsb_host.sv ***
// host end: apb registers steering the can mode and the transmit pin
`timescale 1ns/1ns
module cnsb_host (
	input  wire logic        clock,
	input  wire logic        nrst,
	cnsb_if.host             lnk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [2:0]       chipMode_r,  // chip mode command to the system
	output logic [8:0]       senseMs_r    // cyclic sense period in ms
);
	logic rxS, intS, stuckS, wakeS, intSeen_r;
	logic canNormal_r, wakeEn_r, txd_r, statRd_r;
	logic [1:0] slew_r;
	logic acc, wr, statRd_nxt, csN_r;

	cnsb_sync #(.INIT(1'b0)) uRx (.clock(clock), .nrst(nrst), .din(lnk.rxd),       .dout(rxS));
	cnsb_sync #(.INIT(1'b1)) uIn (.clock(clock), .nrst(nrst), .din(lnk.intN),      .dout(intS));
	cnsb_sync #(.INIT(1'b0)) uSt (.clock(clock), .nrst(nrst), .din(lnk.stuckFlag), .dout(stuckS));
	cnsb_sync #(.INIT(1'b0)) uWk (.clock(clock), .nrst(nrst), .din(lnk.busWake),   .dout(wakeS));

	assign acc = psel && penable;
	assign wr  = acc && pwrite;
	// status read in its access cycle
	assign statRd_nxt = acc && !pwrite && pready && paddr == cnsb_pkg::REG_STAT;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// power-on: normal, slew zero, tx recessive
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			canNormal_r <= 1'b1;
			wakeEn_r    <= 1'b0;
			slew_r      <= 2'h0;
			txd_r       <= 1'b1;
			chipMode_r  <= cnsb_pkg::CHIP_NREQ;
			senseMs_r   <= cnsb_pkg::PERIOD_RST;
		end else if (wr && paddr == cnsb_pkg::REG_CTRL) begin
			canNormal_r <= pwdata[cnsb_pkg::CTRL_NORMAL];
			wakeEn_r    <= pwdata[cnsb_pkg::CTRL_WAKEEN];
			slew_r      <= pwdata[cnsb_pkg::CTRL_SLEW +: 2];
			txd_r       <= pwdata[cnsb_pkg::CTRL_TXD];
			chipMode_r  <= pwdata[cnsb_pkg::CTRL_CHIP +: 3];
		end else if (wr && paddr == cnsb_pkg::REG_PERIOD && pwdata[8:0] >= 9'(cnsb_pkg::PERIOD_MIN_MS)) begin
			senseMs_r <= pwdata[8:0];
		end
	end

	// ----------------------------------------
	// read path and device status read strobe
	// ----------------------------------------
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prdata    <= 32'h0000_0000;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			statRd_r  <= 1'b0;
			csN_r     <= 1'b1;
			intSeen_r <= 1'b0;
		end else begin
			pready   <= psel && !penable;
			pslverr  <= psel && !penable && paddr != cnsb_pkg::REG_CTRL
				&& paddr != cnsb_pkg::REG_STAT && paddr != cnsb_pkg::REG_PERIOD;
			statRd_r <= statRd_nxt;
			// select stays low two cycles, else the device pin filter swallows it
			csN_r    <= !(statRd_nxt || statRd_r);
			// set wins over the read clear
			if (!intS) intSeen_r <= 1'b1;
			else if (statRd_nxt) intSeen_r <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				cnsb_pkg::REG_CTRL: prdata <= {20'h00000, 1'b0, chipMode_r, 3'h0, txd_r, slew_r, wakeEn_r, canNormal_r};
				cnsb_pkg::REG_STAT: prdata <= {27'h0000000, intSeen_r, wakeS, stuckS, 1'b0, rxS};
				cnsb_pkg::REG_PERIOD: prdata <= {23'h000000, senseMs_r};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign lnk.txd       = txd_r;
	assign lnk.csN       = csN_r;
	assign lnk.canNormal = canNormal_r;
	assign lnk.wakeEn    = wakeEn_r;
	assign lnk.slew      = slew_r;
	assign lnk.statRd    = statRd_r;
endmodule : cnsb_host

// *** cnsb_chk.sv ***
// concurrent checks on the host to device link
`timescale 1ns/1ns
module cnsb_chk (
	input wire logic       clock,
	input wire logic       nrst,
	input wire logic       txd,
	input wire logic       rxd,
	input wire logic       csN,
	input wire logic       canNormal,
	input wire logic       wakeEn,
	input wire logic [1:0] slew,
	input wire logic       statRd,
	input wire logic       stuckFlag,
	input wire logic       busWake,
	input wire logic       intN
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic [11:0] lowCnt_r;  // cycles of transmit held low
	logic [3:0]  sinceRd_r; // cycles since a status read
	// low time of transmit, saturating
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			lowCnt_r <= 12'h000;
		else
			lowCnt_r <= txd ? 12'h000 : lowCnt_r + {11'h000, lowCnt_r != 12'hfff};
	end
	// age of the last status read, saturating
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			sinceRd_r <= 4'hf;
		else
			sinceRd_r <= statRd ? 4'h0 : sinceRd_r + {3'h0, sinceRd_r != 4'hf};
	end
	sequence s_txStuck;
		(!txd)[*5] ##0 stuckFlag;
	endsequence
	sequence s_sleepFlag;
		(!canNormal)[*5] ##0 busWake;
	endsequence
	// --------------------------------
	// assertions
	// --------------------------------
	a_int_width: assert property ($fell(intN) |-> ##99 !intN ##1 intN)
		else $error("wake pulse is not 100 cycles wide");
	a_stuck_set: assert property (lowCnt_r == 12'h7da |-> stuckFlag)
		else $error("stuck flag missing after long dominant");
	a_stuck_early: assert property ($rose(stuckFlag) |-> lowCnt_r >= 12'h7d0)
		else $error("stuck flag set before the timeout");
	a_stuck_hold: assert property (s_txStuck |=> stuckFlag)
		else $error("stuck flag cleared while still dominant");
	a_stuck_clear: assert property ($fell(stuckFlag) |-> sinceRd_r < 4'h8)
		else $error("stuck flag cleared without a read");
	a_wake_hold: assert property (s_sleepFlag |=> busWake)
		else $error("bus wake flag cleared in sleep");
	a_wake_clear: assert property ($fell(busWake) |-> sinceRd_r < 4'h8)
		else $error("bus wake flag cleared without a read");
	a_wake_gate: assert property ($rose(busWake) |-> wakeEn && !canNormal)
		else $error("bus wake seen without enable in sleep");
	a_cs_read: assert property (statRd |-> !csN)
		else $error("chip select idle during status read");
	a_reset_dflt: assert property ($rose(nrst) |-> canNormal && slew == 2'h0 && txd && intN)
		else $error("link defaults wrong after reset");
endmodule : cnsb_chk

// *** cnsb_tb_top.sv ***
// self-checking bench joining the host and device ends
`timescale 1ns/1ns
module cnsb_tb_top;
	logic        clock, nrst, psel, penable, pwrite, railOn, extDom, ocIn, senseIn, t, se;
	logic        pready, pslverr, busDrive, driverOn, wakeRxOn, senseSw, stopExit, busDom;
	logic [1:0]  slewOut;
	logic [2:0]  chipMode;
	logic [7:0]  paddr;
	logic [8:0]  senseMs;
	logic [31:0] pwdata, prdata, q;
	int          nErrors, cmpCount, nFall, n;
	cnsb_if lnk ();
	// bus level: our driver or an outside node
	assign busDom = (driverOn & busDrive) | extDom;
	cnsb_host i_cnsb_host (.clock(clock), .nrst(nrst), .lnk(lnk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chipMode_r(chipMode), .senseMs_r(senseMs));
	cnsb_device i_cnsb_device (.clock(clock), .nrst(nrst), .lnk(lnk), .chipMode(chipMode), .railOn(railOn),
		.busDomIn(busDom), .ocIn(ocIn), .senseIn(senseIn), .senseMs(senseMs), .busDrive_r(busDrive),
		.driverOn_r(driverOn), .wakeRxOn_r(wakeRxOn), .slewOut_r(slewOut), .senseSwitch_r(senseSw),
		.stopExit_r(stopExit));
	cnsb_chk i_cnsb_chk (.clock(clock), .nrst(nrst), .txd(lnk.txd), .rxd(lnk.rxd), .csN(lnk.csN),
		.canNormal(lnk.canNormal), .wakeEn(lnk.wakeEn), .slew(lnk.slew), .statRd(lnk.statRd),
		.stuckFlag(lnk.stuckFlag), .busWake(lnk.busWake), .intN(lnk.intN));
	always #50 clock = ~clock;
	// count wake pulses on the host interrupt
	always @(posedge clock) if (nrst && $fell(lnk.intN)) nFall++;
	// --------------------------------
	// tasks
	// --------------------------------
	function automatic logic [31:0] ctrl(input logic nm, we, input logic [1:0] sl, input logic tx,
		input logic [2:0] cm);
		return {21'h0, cm, 3'h0, tx, sl, we, nm};
	endfunction : ctrl
	task automatic chk(input logic [31:0] got, exp);
		cmpCount++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask : rd
	task automatic wint(input int lim);
		n = 0;
		while (lnk.intN !== 1'b0 && n < lim) begin
			@(posedge clock);
			n++;
		end
	endtask : wint
	task automatic pulses;
		int w;
		repeat (3) begin
			w = 20 + $urandom % 400;
			extDom <= 1'b1;
			repeat (w) @(posedge clock);
			extDom <= 1'b0;
			repeat (w) @(posedge clock);
		end
	endtask : pulses
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		clock = 1'b0;
		nrst = 1'b0;
		{psel, penable, pwrite, extDom, ocIn, senseIn} = '0;
		railOn = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(32'hed0da946));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		rd(cnsb_pkg::REG_CTRL, 32'h71d, ctrl(1'b1, 1'b0, 2'h0, 1'b1, cnsb_pkg::CHIP_NREQ));
		rd(cnsb_pkg::REG_STAT, 32'h1, 32'h0);
		apb(1'b1, cnsb_pkg::REG_PERIOD, 32'h3);
		rd(cnsb_pkg::REG_PERIOD, 32'h1ff, 32'h5);
		apb(1'b0, 8'h0c, 32'h0);
		chk({q[30:0], se}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			t = 1'($urandom);
			apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b1, 1'b0, 2'(i), t, cnsb_pkg::CHIP_NORMAL));
			repeat (20) @(posedge clock);
			chk({30'h0, slewOut}, 32'(i % 4));
			rd(cnsb_pkg::REG_STAT, 32'h1, {31'h0, t});
		end
		railOn <= 1'b0;
		repeat (8) @(posedge clock);
		chk({31'h0, lnk.rxd}, 32'h0);
		railOn <= 1'b1;
		apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b1, 1'b0, 2'h0, 1'b0, cnsb_pkg::CHIP_NORMAL));
		repeat (2100) @(posedge clock);
		chk({31'h0, driverOn}, 32'h0);
		rd(cnsb_pkg::REG_STAT, 32'h4, 32'h4);
		rd(cnsb_pkg::REG_STAT, 32'h4, 32'h4);
		apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b1, 1'b0, 2'h0, 1'b1, cnsb_pkg::CHIP_NORMAL));
		repeat (8) @(posedge clock);
		chk({31'h0, driverOn}, 32'h1);
		apb(1'b0, cnsb_pkg::REG_STAT, 32'h0);
		repeat (8) @(posedge clock);
		rd(cnsb_pkg::REG_STAT, 32'h4, 32'h0);
		$display("test normal done");
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b0, 1'(e), 2'h0, 1'b1, cnsb_pkg::CHIP_NORMAL));
			repeat (8) @(posedge clock);
			chk({30'h0, driverOn, wakeRxOn}, 32'(e));
			pulses();
			repeat (20) @(posedge clock);
			chk({31'h0, lnk.busWake}, 32'(e));
		end
		rd(cnsb_pkg::REG_STAT, 32'h8, 32'h8);
		apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b1, 1'b0, 2'h0, 1'b1, cnsb_pkg::CHIP_NORMAL));
		repeat (8) @(posedge clock);
		apb(1'b0, cnsb_pkg::REG_STAT, 32'h0);
		repeat (8) @(posedge clock);
		rd(cnsb_pkg::REG_STAT, 32'h9, 32'h1);
		$display("test sleep done");
		apb(1'b1, cnsb_pkg::REG_CTRL, ctrl(1'b0, 1'b0, 2'h0, 1'b1, cnsb_pkg::CHIP_STOP));
		repeat (8) @(posedge clock);
		chk({29'h0, senseSw, driverOn, lnk.rxd}, 32'h4);
		nFall = 0;
		apb(1'b0, cnsb_pkg::REG_STAT, 32'h0);
		wint(2000);
		chk(32'(n >= 590 && n <= 615), 32'h1);
		repeat (150) @(posedge clock);
		ocIn <= 1'b1;
		repeat (300) @(posedge clock);
		ocIn <= 1'b0;
		wint(1500);
		chk(32'(n), 32'h5dc);
		ocIn <= 1'b1;
		wint(3000);
		chk({31'h0, stopExit}, 32'h1);
		ocIn <= 1'b0;
		chk(32'(n >= 1145 && n <= 1175), 32'h1);
		repeat (150) @(posedge clock);
		senseIn <= 1'b1;
		wint(60000);
		senseIn <= 1'b0;
		chk(32'(n >= 1000 && n < 51500), 32'h1);
		repeat (150) @(posedge clock);
		chk(32'(nFall), 32'h3);
		$display("test stop done");
		report_and_stop();
	end
	// watchdog against a hung handshake or wait
	initial begin
		repeat (90000) @(posedge clock);
		nErrors++;
		report_and_stop();
	end
endmodule : cnsb_tb_top
